// *** design/sram_port_pkg.sv ***
// Shared constants, field layouts and carrier types of the pipelined SRAM port.
package sram_port_pkg;

	// Variant geometry: 1M words of 36 bits, four lanes of nine bits.
	localparam int ADDR_W    = 20;
	localparam int DATA_W    = 36;
	localparam int BYTE_W    = 9;
	localparam int NUM_BYTES = DATA_W / BYTE_W;
	localparam int BURST_W   = 2;

	// Clock rate of this build against the fastest supported grade.
	localparam int CLK_PERIOD_PS = 5000;
	localparam int MAX_CLK_MHZ   = 250;
	localparam int CLK_MHZ       = 1000000 / CLK_PERIOD_PS;

	// APB register map, byte addresses.
	localparam int          APB_ADDR_W = 12;
	localparam logic [11:0] CFG_OFS    = 12'h000;
	localparam logic [11:0] STAT_OFS   = 12'h004;
	localparam logic [11:0] RDCNT_OFS  = 12'h008;
	localparam logic [11:0] WRCNT_OFS  = 12'h00C;

	// Configuration fields and reset value.
	localparam int          CFG_INTERLEAVE_BIT = 0;
	localparam int          CFG_ENABLE_BIT     = 1;
	localparam logic [31:0] CFG_RESET          = 32'h0000_0002;

	// Status fields.
	localparam int STAT_SLEEP_BIT = 0;
	localparam int STAT_DRIVE_BIT = 1;
	localparam int STAT_STALL_BIT = 2;

	// Operation carried by one pipeline stage.
	typedef enum logic [1:0] {OP_IDLE, OP_READ, OP_WRITE} op_t;

	// One pipeline stage: operation, word address and byte strobes.
	typedef struct packed {
		op_t                  op;
		logic [ADDR_W-1:0]    addr;
		logic [NUM_BYTES-1:0] bw_n;
	} stage_t;

endpackage

// *** design/sram_array.sv ***
// Storage array with byte-lane writes and an asynchronous read port.
`timescale 1ns/1ps
module sram_array #(
	parameter int MEM_ADDR_W = 20,
	parameter int DATA_W_P   = 36,
	parameter int BYTE_W_P   = 9
) (
	// Clock.
	input  wire logic                              clk,
	// Write port.
	input  wire logic                              wr_en,
	input  wire logic [MEM_ADDR_W-1:0]             wr_addr,
	input  wire logic [DATA_W_P-1:0]               wr_data,
	input  wire logic [DATA_W_P/BYTE_W_P-1:0]      wr_bw_n,
	// Read port.
	input  wire logic [MEM_ADDR_W-1:0]             rd_addr,
	output logic      [DATA_W_P-1:0]               rd_data
);
	localparam int LANES = DATA_W_P / BYTE_W_P;

	initial begin
		if (LANES * BYTE_W_P != DATA_W_P || MEM_ADDR_W < 2) begin
			$error("sram_array: unsupported geometry");
		end
	end

	logic [DATA_W_P-1:0] mem [2**MEM_ADDR_W];

	// Only lanes whose strobe is low are written; the rest keep their old value.
	always_ff @(posedge clk) begin
		if (wr_en) begin
			for (int i = 0; i < LANES; i++) begin
				if (!wr_bw_n[i]) begin
					mem[wr_addr][i*BYTE_W_P +: BYTE_W_P] <= wr_data[i*BYTE_W_P +: BYTE_W_P];
				end
			end
		end
	end

	// Read is combinational so the caller can merge a write that commits this same edge.
	assign rd_data = mem[rd_addr];

	// A masked lane keeps the value it held before the write.
	for (genvar g = 0; g < LANES; g++) begin : g_lane_chk
		a_lane_keep: assert property (@(posedge clk)
			(wr_en && wr_bw_n[g] && rd_addr == wr_addr)
			|=> (rd_addr != $past(wr_addr))
			|| rd_data[g*BYTE_W_P +: BYTE_W_P] == $past(rd_data[g*BYTE_W_P +: BYTE_W_P]))
			else $error("masked byte lane changed on write");
	end

endmodule

// *** design/sram_port.sv ***
// Pipelined synchronous SRAM port with APB configuration and status registers.
//
// Implementation choices: register access over APB and the address map.
`timescale 1ns/1ps
module sram_port
	import sram_port_pkg::*;
#(
	parameter int MEM_ADDR_W = sram_port_pkg::ADDR_W
) (
	// Clock and reset.
	input  wire logic                                 pclk,
	input  wire logic                                 presetn,
	// APB slave.
	input  wire logic [sram_port_pkg::APB_ADDR_W-1:0] paddr,
	input  wire logic                                 psel,
	input  wire logic                                 penable,
	input  wire logic                                 pwrite,
	input  wire logic [31:0]                          pwdata,
	output logic      [31:0]                          prdata,
	output logic                                      pready,
	output logic                                      pslverr,
	// Memory bus: address and control.
	input  wire logic [sram_port_pkg::ADDR_W-1:0]     address_in,
	input  wire logic                                 chip_select_a_n,
	input  wire logic                                 chip_select_b,
	input  wire logic                                 chip_select_c_n,
	input  wire logic                                 write_enable_n,
	input  wire logic                                 burst_advance,
	input  wire logic [sram_port_pkg::NUM_BYTES-1:0]  byte_write_strobe_n,
	input  wire logic                                 clock_gate_n,
	input  wire logic                                 output_enable_n,
	input  wire logic                                 sleep_request,
	// Memory bus: data pins.
	input  wire logic [sram_port_pkg::DATA_W-1:0]     dq_in,
	output logic      [sram_port_pkg::DATA_W-1:0]     dq_out,
	output logic                                      dq_oe_n
);
	import sram_port_pkg::*;

	initial begin
		if (MEM_ADDR_W < BURST_W || MEM_ADDR_W > ADDR_W) begin
			$error("sram_port: MEM_ADDR_W out of range");
		end
		if (CLK_MHZ > MAX_CLK_MHZ) begin
			$error("sram_port: clock faster than the fastest grade");
		end
		if (DATA_W != 36 || ADDR_W != 20) begin
			$error("sram_port: variant geometry mismatch");
		end
	end

	// Configuration and status registers.
	logic [31:0]         cfg_ff;
	logic [31:0]         rd_cnt_ff;
	logic [31:0]         wr_cnt_ff;
	logic [31:0]         prdata_ff;
	logic [31:0]         stat_word;
	logic                apb_hit;
	// Pipeline stages.
	stage_t              s1_ff;
	stage_t              s2_ff;
	stage_t              s3_ff;
	stage_t              nxt_s1;
	logic [DATA_W-1:0]   din_ff;
	logic [DATA_W-1:0]   dout_ff;
	logic                drive_ff;
	logic [DATA_W-1:0]   nxt_dout;
	logic [DATA_W-1:0]   arr_rd;
	// Burst tracking.
	logic [ADDR_W-1:0]   burst_base_ff;
	logic [BURST_W-1:0]  burst_cnt_ff;
	op_t                 burst_op_ff;
	logic [BURST_W-1:0]  nxt_cnt;
	logic [BURST_W-1:0]  burst_low;
	// Qualifiers.
	logic                adv_en;
	logic                all_sel;
	logic                commit;

	// An edge only counts when the gate pin is low; otherwise the previous cycle extends.
	assign adv_en  = !clock_gate_n;
	assign all_sel = !chip_select_a_n && chip_select_b && !chip_select_c_n;
	assign commit  = adv_en && (s3_ff.op == OP_WRITE);

	// Burst step in the order chosen by the configuration bit.
	assign nxt_cnt   = burst_cnt_ff + 2'h1;
	assign burst_low = cfg_ff[CFG_INTERLEAVE_BIT]
		? (burst_base_ff[BURST_W-1:0] ^ nxt_cnt)
		: (burst_base_ff[BURST_W-1:0] + nxt_cnt);

	// Decode of the new cycle: load, advance or deselect.
	always_comb begin
		nxt_s1      = '0;
		nxt_s1.op   = OP_IDLE;
		nxt_s1.bw_n = byte_write_strobe_n;
		if (sleep_request || !cfg_ff[CFG_ENABLE_BIT]) begin
			nxt_s1.op = OP_IDLE;
		end else if (burst_advance) begin
			nxt_s1.op   = burst_op_ff;
			nxt_s1.addr = {burst_base_ff[ADDR_W-1:BURST_W], burst_low};
		end else if (all_sel) begin
			nxt_s1.op   = write_enable_n ? OP_READ : OP_WRITE;
			nxt_s1.addr = address_in;
		end
	end

	// Input register stage: address, control and strobe pins land here first; write data has its own register.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_ff    <= '{op: OP_IDLE, addr: '0, bw_n: '1};
			s2_ff    <= '{op: OP_IDLE, addr: '0, bw_n: '1};
			s3_ff    <= '{op: OP_IDLE, addr: '0, bw_n: '1};
		end else if (adv_en) begin
			s1_ff <= nxt_s1;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end

	// Write data is taken two edges after its address, in step with the third stage.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			din_ff <= '0;
		end else if (adv_en) begin
			din_ff <= dq_in;
		end
	end

	// Burst base and count, reloaded by every fresh load and held across a stall.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			burst_base_ff <= '0;
			burst_cnt_ff  <= '0;
			burst_op_ff   <= OP_IDLE;
		end else if (adv_en) begin
			if (sleep_request || !cfg_ff[CFG_ENABLE_BIT]) begin
				burst_op_ff <= OP_IDLE;
			end else if (burst_advance) begin
				burst_cnt_ff <= nxt_cnt;
			end else begin
				burst_base_ff <= address_in;
				burst_cnt_ff  <= '0;
				burst_op_ff   <= all_sel ? (write_enable_n ? OP_READ : OP_WRITE) : OP_IDLE;
			end
		end
	end

	sram_array #(
		.MEM_ADDR_W (MEM_ADDR_W),
		.DATA_W_P   (DATA_W),
		.BYTE_W_P   (BYTE_W)
	) u_array (
		.clk     (pclk),
		.wr_en   (commit),
		.wr_addr (s3_ff.addr[MEM_ADDR_W-1:0]),
		.wr_data (din_ff),
		.wr_bw_n (s3_ff.bw_n),
		.rd_addr (s2_ff.addr[MEM_ADDR_W-1:0]),
		.rd_data (arr_rd)
	);

	// A write committing on this same edge to the read's word is merged lane by lane,
	// so back-to-back write then read returns the new data without a bubble.
	always_comb begin
		nxt_dout = arr_rd;
		if (s3_ff.op == OP_WRITE && s3_ff.addr[MEM_ADDR_W-1:0] == s2_ff.addr[MEM_ADDR_W-1:0]) begin
			for (int i = 0; i < NUM_BYTES; i++) begin
				if (!s3_ff.bw_n[i]) begin
					nxt_dout[i*BYTE_W +: BYTE_W] = din_ff[i*BYTE_W +: BYTE_W];
				end
			end
		end
	end

	// Output register: read data leaves here; writes turn the drivers off in their data phase.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dout_ff  <= '0;
			drive_ff <= 1'b0;
		end else if (adv_en) begin
			unique case (s2_ff.op)
				OP_READ: begin
					dout_ff  <= nxt_dout;
					drive_ff <= 1'b1;
				end
				OP_WRITE: begin
					drive_ff <= 1'b0;
				end
				OP_IDLE: begin
					drive_ff <= 1'b0;
				end
				default: begin
					drive_ff <= 1'b0;
				end
			endcase
		end
	end

	// The enable pin acts without the clock, so it gates the registered drive directly.
	assign dq_out  = dout_ff;
	assign dq_oe_n = output_enable_n || !drive_ff;

	// Transfer counters for software; they wrap rather than saturate.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_cnt_ff <= '0;
			wr_cnt_ff <= '0;
		end else if (adv_en) begin
			if (s2_ff.op == OP_READ) begin
				rd_cnt_ff <= rd_cnt_ff + 32'h0000_0001;
			end
			if (commit) begin
				wr_cnt_ff <= wr_cnt_ff + 32'h0000_0001;
			end
		end
	end

	// Configuration register; burst order is meant to be set while the bus is idle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_ff <= CFG_RESET;
		end else if (psel && penable && pwrite && paddr == CFG_OFS) begin
			cfg_ff <= pwdata & 32'h0000_0003;
		end
	end

	// Status word shows live port state.
	always_comb begin
		stat_word                 = '0;
		stat_word[STAT_SLEEP_BIT] = sleep_request;
		stat_word[STAT_DRIVE_BIT] = drive_ff;
		stat_word[STAT_STALL_BIT] = clock_gate_n;
	end

	assign apb_hit = paddr == CFG_OFS || paddr == STAT_OFS
		|| paddr == RDCNT_OFS || paddr == WRCNT_OFS;

	// Read data is latched in the setup cycle so the access phase answers from a flop.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff <= '0;
		end else if (psel && !penable && !pwrite) begin
			unique case (paddr)
				CFG_OFS:   prdata_ff <= cfg_ff;
				STAT_OFS:  prdata_ff <= stat_word;
				RDCNT_OFS: prdata_ff <= rd_cnt_ff;
				WRCNT_OFS: prdata_ff <= wr_cnt_ff;
				default:   prdata_ff <= '0;
			endcase
		end
	end

	// Every access completes in its first access cycle; unmapped addresses answer an error.
	assign prdata  = prdata_ff;
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !apb_hit;

	// Checks on the pipeline.
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic take_rd;
	logic take_wr;
	assign take_rd = adv_en && nxt_s1.op == OP_READ;
	assign take_wr = adv_en && nxt_s1.op == OP_WRITE;

	a_input_capture: assert property (
		(adv_en && !burst_advance && all_sel && !sleep_request && cfg_ff[CFG_ENABLE_BIT])
		|=> s1_ff.addr == $past(address_in) && s1_ff.bw_n == $past(byte_write_strobe_n))
		else $error("address or strobes not captured");

	a_read_latency: assert property (
		take_rd ##1 adv_en ##1 adv_en |=> drive_ff)
		else $error("read data not driven two edges after address");

	a_read_data_reg: assert property (
		(adv_en && s2_ff.op == OP_READ) |=> dout_ff == $past(nxt_dout))
		else $error("output register missed read data");

	a_stall_hold: assert property (
		!adv_en |=> $stable(dout_ff) && $stable(drive_ff) && $stable(s1_ff) && $stable(s3_ff))
		else $error("state changed on a gated edge");

	a_deselect_idle: assert property (
		(adv_en && !burst_advance && !all_sel) |=> s1_ff.op == OP_IDLE)
		else $error("cycle selected without all chip selects");

	a_oe_async: assert property (
		output_enable_n |-> dq_oe_n)
		else $error("drivers on while output enable inactive");

	a_write_tristate: assert property (
		take_wr ##1 adv_en ##1 adv_en |=> dq_oe_n)
		else $error("drivers on during write data phase");

	// The write must reach the commit stage with the read right behind it, no bubble between.
	a_back_to_back: assert property (
		take_wr ##1 take_rd ##1 adv_en |=> s3_ff.op == OP_WRITE && s2_ff.op == OP_READ)
		else $error("write then read did not flow without a bubble");

	a_burst_order: assert property (
		(adv_en && burst_advance && !sleep_request && cfg_ff[CFG_ENABLE_BIT]
			&& cfg_ff[CFG_INTERLEAVE_BIT])
		|=> s1_ff.addr[BURST_W-1:0]
			== ($past(burst_base_ff[BURST_W-1:0]) ^ $past(nxt_cnt)))
		else $error("interleaved burst address wrong");

	c_read: cover property (take_rd ##1 adv_en ##1 adv_en ##1 !dq_oe_n);
	c_write_read: cover property (take_wr ##1 take_rd);
	c_stall: cover property (take_rd ##1 !adv_en [*2] ##1 adv_en);
	c_burst: cover property (take_rd ##1 (adv_en && burst_advance) [*3]);

endmodule

// *** verif/mem_ctrl_model.sv ***
// Memory controller model that drives the port's address, control and write data pins.
`timescale 1ns/1ps
module mem_ctrl_model (
	// Clock, reset and stall.
	input  wire logic                                pclk,
	input  wire logic                                presetn,
	input  wire logic                                clock_gate_n,
	// Requests from the bench.
	input  wire logic                                ld,
	input  wire logic                                bst,
	input  wire logic                                wr,
	input  wire logic [1:0]                          miss,
	input  wire logic [sram_port_pkg::ADDR_W-1:0]    a,
	input  wire logic [sram_port_pkg::DATA_W-1:0]    d,
	input  wire logic [sram_port_pkg::NUM_BYTES-1:0] bw,
	// Pins towards the port.
	output logic      [sram_port_pkg::ADDR_W-1:0]    address_in,
	output logic                                     chip_select_a_n,
	output logic                                     chip_select_b,
	output logic                                     chip_select_c_n,
	output logic                                     write_enable_n,
	output logic                                     burst_advance,
	output logic      [sram_port_pkg::NUM_BYTES-1:0] byte_write_strobe_n,
	output logic      [sram_port_pkg::DATA_W-1:0]    dq_in
);
	import sram_port_pkg::*;
	logic              wv_ff;
	logic [DATA_W-1:0] wd_ff;
	// Selects go inactive when idle; miss holds off exactly one of the three.
	assign chip_select_a_n     = !ld || miss == 2'h1;
	assign chip_select_b       = ld && miss != 2'h2;
	assign chip_select_c_n     = !ld || miss == 2'h3;
	assign write_enable_n      = !wr;
	assign burst_advance       = bst;
	assign address_in          = a;
	assign byte_write_strobe_n = bw;
	// Write data trails its address by two counted edges; a released bus toggles so no
	// stale word can pass for valid data.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wv_ff <= 1'b0;
			wd_ff <= '0;
			dq_in <= '0;
		end else if (!clock_gate_n) begin
			wv_ff <= wr && (ld || bst);
			wd_ff <= d;
			dq_in <= wv_ff ? wd_ff : ~dq_in;
		end
	end
endmodule

// *** verif/test_pipelined_sync_sram_port.sv ***
// Bench for the pipelined SRAM port: controller model, APB master and scoreboard.
`timescale 1ns/1ps
module test_pipelined_sync_sram_port;
	import sram_port_pkg::*;
	localparam int AW = 8;
	// Clock, reset and APB.
	logic                 pclk = 1'b0;
	logic                 presetn = 1'b0;
	logic [11:0]          paddr = 12'h000;
	logic                 psel = 1'b0;
	logic                 penable = 1'b0;
	logic                 pwrite = 1'b0;
	logic [31:0]          pwdata = 32'h0;
	logic [31:0]          prdata;
	logic                 pready, pslverr;
	// Memory bus.
	logic                 clock_gate_n = 1'b0;
	logic                 output_enable_n = 1'b0;
	logic                 sleep_request = 1'b0;
	logic                 ld = 1'b0, bst = 1'b0, wr = 1'b0;
	logic [1:0]           miss = 2'h0;
	logic [ADDR_W-1:0]    a = '0;
	logic [DATA_W-1:0]    d = '0;
	logic [NUM_BYTES-1:0] bw = '0;
	logic [ADDR_W-1:0]    address_in;
	logic                 cs_a_n, cs_b, cs_c_n, we_n, adv, dq_oe_n;
	logic [NUM_BYTES-1:0] bw_pin;
	logic [DATA_W-1:0]    dq_in, dq_out;
	// Scoreboard state.
	logic [DATA_W-1:0]    mem [2**AW];
	logic [DATA_W-1:0]    rq [$];
	logic [35:0]          aq [$];
	logic [1:0]           rd_pipe;
	logic                 chk_ff, chk_rd, issue_rd = 1'b0;
	logic                 port_on = 1'b1, intl = 1'b0, bst_ok = 1'b0, last_wr = 1'b0;
	logic [AW-1:0]        base = '0;
	logic [1:0]           beat = 2'h0;
	logic [31:0]          seed = 32'h15;
	int                   errors = 0, checked = 0, rd_n = 0, wr_n = 0;

	sram_port #(.MEM_ADDR_W(AW)) i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .address_in(address_in), .chip_select_a_n(cs_a_n),
		.chip_select_b(cs_b), .chip_select_c_n(cs_c_n), .write_enable_n(we_n),
		.burst_advance(adv), .byte_write_strobe_n(bw_pin), .clock_gate_n(clock_gate_n),
		.output_enable_n(output_enable_n), .sleep_request(sleep_request), .dq_in(dq_in),
		.dq_out(dq_out), .dq_oe_n(dq_oe_n));
	mem_ctrl_model i_ctrl (.pclk(pclk), .presetn(presetn), .clock_gate_n(clock_gate_n),
		.ld(ld), .bst(bst), .wr(wr), .miss(miss), .a(a), .d(d), .bw(bw),
		.address_in(address_in), .chip_select_a_n(cs_a_n), .chip_select_b(cs_b),
		.chip_select_c_n(cs_c_n), .write_enable_n(we_n), .burst_advance(adv),
		.byte_write_strobe_n(bw_pin), .dq_in(dq_in));

	// Clock of 5 ns period.
	always #2.5 pclk = ~pclk;

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic check(input logic [35:0] ex, input logic [35:0] got);
		checked++;
		if (got !== ex) begin
			errors++;
			$display("FAIL at %0t: expected %h got %h", $time, ex, got);
		end
	endtask

	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// One APB transfer; a read notes its expected error flag and data first.
	task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] dd,
			input logic [32:0] ex);
		if (!w) aq.push_back({3'h0, ex});
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= dd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (!pready) @(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	// One memory bus cycle; the reference array is updated at issue so a read right
	// after a write to the same word expects the merged word.
	task automatic op(input logic g, s, l, b, w, input logic [1:0] m,
			input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] dd,
			input logic [NUM_BYTES-1:0] bb, input logic oe);
		logic          tk;
		logic [AW-1:0] wa;
		w = b ? last_wr : w;
		tk = !g && port_on && (b ? bst_ok : l && m == 2'h0 && !s);
		wa = ad[AW-1:0];
		if (tk && b) begin
			beat = beat + 2'h1;
			wa = {base[AW-1:2], intl ? base[1:0] ^ beat : base[1:0] + beat};
		end else if (tk) begin
			base = wa;
			beat = 2'h0;
			last_wr = w;
		end
		if (!g) bst_ok = tk;
		if (tk && w) begin
			wr_n++;
			for (int i = 0; i < NUM_BYTES; i++)
				if (!bb[i]) mem[wa][i*BYTE_W+:BYTE_W] = dd[i*BYTE_W+:BYTE_W];
		end
		if (tk && !w) begin
			rd_n++;
			rq.push_back(mem[wa]);
		end
		issue_rd <= tk && !w;
		clock_gate_n <= g;
		sleep_request <= s;
		ld <= l;
		bst <= b;
		wr <= w;
		miss <= m;
		a <= ad;
		d <= dd;
		bw <= bb;
		output_enable_n <= oe;
		@(posedge pclk);
	endtask

	task automatic idle(input int n, input logic s);
		repeat (n) op(1'b0, s, 1'b0, 1'b0, 1'b0, 2'h0, '0, '0, '0, 1'b0);
	endtask

	// Random mix of stalls, deselects, sleep, bursts, strobes and output enable.
	task automatic run(input int n);
		logic [31:0] r, ra;
		logic        b;
		for (int i = 0; i < n; i++) begin
			r = rnd();
			ra = rnd();
			b = bst_ok && r[1];
			op(r[4:2] == 3'h0, !b && r[7:5] == 3'h0, !b, b, r[8], r[11] ? r[10:9] : 2'h0,
				ra[ADDR_W-1:0], {rnd(), r[15:12]}, r[19:16], r[22:20] == 3'h0);
		end
	endtask

	// Each counted edge opens a result slot two edges after its request.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_pipe <= 2'h0;
			chk_ff <= 1'b0;
			chk_rd <= 1'b0;
		end else if (!clock_gate_n) begin
			rd_pipe <= {rd_pipe[0], issue_rd};
			chk_ff <= 1'b1;
			chk_rd <= rd_pipe[1];
		end else begin
			chk_ff <= 1'b0;
		end
	end

	// Results are compared mid-cycle, once every output has settled.
	always @(negedge pclk) begin
		if (chk_ff) begin
			check({35'h0, output_enable_n | !chk_rd}, {35'h0, dq_oe_n});
			if (chk_rd) check(rq.pop_front(), dq_out);
		end
	end

	// APB read data is taken at the edge where the access completes.
	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite) check(aq.pop_front(), {3'h0, pslverr, prdata});
	end

	initial begin
		repeat (20000) @(posedge pclk);
		errors++;
		complete_run();
	end

	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, CFG_OFS, '0, {1'b0, CFG_RESET});
		apb(1'b0, STAT_OFS, '0, 33'h0);
		apb(1'b1, RDCNT_OFS, 32'hFFFF_FFFF, '0);
		apb(1'b0, RDCNT_OFS, '0, 33'h0);
		apb(1'b0, 12'h010, '0, 33'h1_0000_0000);
		for (int i = 0; i < 2**AW; i++)
			op(1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 2'h0, ADDR_W'(i), {rnd(), 4'hA}, '0, 1'b0);
		run(400);
		idle(4, 1'b0);
		apb(1'b1, CFG_OFS, 32'h3, '0);
		intl = 1'b1;
		run(400);
		idle(4, 1'b0);
		apb(1'b1, CFG_OFS, 32'h1, '0);
		port_on = 1'b0;
		run(40);
		idle(4, 1'b0);
		apb(1'b1, CFG_OFS, 32'h2, '0);
		port_on = 1'b1;
		intl = 1'b0;
		op(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 2'h0, '0, '0, '0, 1'b0);
		apb(1'b0, STAT_OFS, '0, 33'h5);
		idle(1, 1'b0);
		apb(1'b0, RDCNT_OFS, '0, {1'b0, 32'(rd_n)});
		apb(1'b0, WRCNT_OFS, '0, {1'b0, 32'(wr_n)});
		// Move the configuration off its reset value so the mid-run reset is visible.
		apb(1'b1, CFG_OFS, 32'h3, '0);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, CFG_OFS, '0, {1'b0, CFG_RESET});
		apb(1'b0, RDCNT_OFS, '0, 33'h0);
		complete_run();
	end
endmodule
